// file: verilog/prl_pkg.sv
// Contract
// RULE1: below 1 Mbps the rate limit moves in 64 kbps steps.
// RULE2: above 1 Mbps the rate limit moves in 1 Mbps steps.
// RULE3: receive and transmit limits are separate, each held per port.
// RULE4: on a 10 Mbps port a setting above 10 Mbps means no limit.
// RULE5: frame size is DA to FCS, plus gap or preamble bytes if chosen.
// RULE6: ingress meter counts only the class picked by a two-bit selector.
// RULE7: over-rate ingress frames are dropped, or flow control is raised instead.
// RULE8: port-based priority gives every frame of a port one fixed priority; the code uses it only for untagged non-IP frames.
// RULE9: tag and DiffServ priorities remap to 0..3 through programmable tables.
// RULE10: per-queue limits apply only with the global queue-limit enable set.
// RULE11: software puts all involved ports in the same two or four queue split.
// RULE12: ingress queue rate comes from a 7-bit code per queue.
// RULE13: egress queue rate comes from a 7-bit code per queue.
// RULE14: leaky bucket per egress queue stretches the gap between frames.
// RULE15: when queue or port memory is full, drop or raise flow control.
// RULE16: top egress queue runs at its rate, lower ones at a ratio of it.
// RULE17: ratio comes from per-port controls and never limits the top queue.
// RULE18: each 7-bit code maps to a bit refill per tick by a fixed table.
package prl_pkg;
	localparam int NPORT = 5;
	localparam int NQ = 4;
	localparam int BW = 24;
	// per-port register offsets, block number in address bits 7:4
	localparam logic [3:0] R_PCTRL = 4'h0;
	localparam logic [3:0] R_RLCTRL = 4'h1;
	localparam logic [3:0] R_ING0 = 4'h2;
	localparam logic [3:0] R_EGR0 = 4'h6;
	localparam logic [3:0] R_RAT0 = 4'hA;
	localparam logic [3:0] R_STAT = 4'hE;
	// global block and its offsets
	localparam logic [3:0] GBLK = 4'h7;
	localparam logic [3:0] G_CTRL = 4'h0;
	localparam logic [3:0] G_PMAP = 4'h1;
	localparam logic [3:0] G_DMAP0 = 4'h2;
	// field positions
	localparam int PC_SPLIT = 0;
	localparam int PC_TEN = 2;
	localparam int PC_PRIO = 3;
	localparam int PC_IFG = 5;
	localparam int PC_PRE = 6;
	localparam int RL_SEL = 2;
	localparam int RL_FC = 4;
	localparam int GC_QRL = 3;
	// reset values
	localparam logic [6:0] PCTRL_RST = 7'h00;
	localparam logic [4:0] RLCTRL_RST = 5'h00;
	localparam logic [6:0] CODE_RST = 7'h00;
	localparam logic QRL_RST = 1'b0;
	localparam logic [3:0][7:0] RATIO_RST = {8'h08, 8'h04, 8'h02, 8'h01};
	localparam logic [15:0] PMAP_RST = 16'hFA50;
	localparam logic [3:0][31:0] DMAP_RST = {32'hFFFFFFFF, 32'hAAAAAAAA,
		32'h55555555, 32'h00000000};
	// frame size additions in bytes
	localparam logic [12:0] IFG_BYTES = 13'h000C;
	localparam logic [12:0] PRE_BYTES = 13'h0008;
	// rate code ranges
	localparam logic [6:0] CODE_TEN_MAX = 7'h0A;
	localparam logic [6:0] CODE_MBPS_MAX = 7'h64;
	localparam logic [6:0] CODE_KBPS_MAX = 7'h73;
	// timing: refill tick and bits per step per tick
	localparam int CLK_NS = 10;
	localparam int TICK_NS = 125000;
	localparam int TICK_CYC = TICK_NS / CLK_NS;
	localparam int MBPS_BITS = 1000 * TICK_NS / 1000000;
	localparam int KSTEP_BITS = 64 * TICK_NS / 1000000;
	localparam logic signed [BW-1:0] BKT_CAP = 24'sh100000;

	typedef enum logic [1:0] {CL_UNI = 2'h0, CL_MCAST = 2'h1,
		CL_BCAST = 2'h2, CL_FLOOD = 2'h3} prl_class_t;
	typedef enum logic [1:0] {SEL_ALL = 2'h0, SEL_MCAST = 2'h1,
		SEL_BCAST = 2'h2, SEL_FLOOD = 2'h3} prl_sel_t;
	typedef enum logic [1:0] {SPL_ONE = 2'h0, SPL_TWO = 2'h1,
		SPL_FOUR = 2'h2} prl_split_t;

	// code that places no limit at all
	function automatic logic rate_open(input logic [6:0] code,
		input logic ten);
		return (code == 7'h00) || (code > CODE_KBPS_MAX) ||
			(ten && code > CODE_TEN_MAX && code <= CODE_MBPS_MAX); // see RULE4
	endfunction

	// refill bits per tick for a code
	function automatic logic [BW-1:0] rate_bits(input logic [6:0] code);
		if (code <= CODE_MBPS_MAX)
			return BW'(code) * BW'(MBPS_BITS); // see RULE2 see RULE18
		return BW'(code - CODE_MBPS_MAX) * BW'(KSTEP_BITS); // see RULE1
	endfunction
endpackage

// file: verilog/prl_port_rate_limiter.sv
module prl_port_rate_limiter #(
	parameter int TICK_CYCLES = prl_pkg::TICK_CYC
) (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	input wire logic ing_valid_i,
	input wire logic [2:0] ing_port_i,
	input wire logic [10:0] ing_len_i,
	input wire prl_pkg::prl_class_t ing_class_i,
	input wire logic ing_tagged_i,
	input wire logic [2:0] ing_pcp_i,
	input wire logic ing_ip_i,
	input wire logic [5:0] ing_dscp_i,
	input wire logic ing_dst_full_i,
	output logic ing_ack_o,
	output logic ing_drop_o,
	output logic [1:0] ing_prio_o,
	output logic [prl_pkg::NPORT-1:0] ing_fc_o,
	input wire logic eg_valid_i,
	input wire logic [2:0] eg_port_i,
	input wire logic [1:0] eg_queue_i,
	input wire logic [10:0] eg_len_i,
	output logic eg_ready_o
);
	import prl_pkg::*;

	localparam int NB = NPORT * NQ;
	localparam int TW = $clog2(TICK_CYCLES + 1);

	logic [NPORT-1:0][6:0] pctrl, next_pctrl;
	logic [NPORT-1:0][4:0] rlctrl, next_rlctrl;
	logic [NPORT-1:0][NQ-1:0][6:0] ing_code, next_ing_code;
	logic [NPORT-1:0][NQ-1:0][6:0] eg_code, next_eg_code;
	logic [NPORT-1:0][NQ-1:0][7:0] ratio, next_ratio;
	logic qrl_en, next_qrl_en;
	logic [15:0] pmap, next_pmap;
	logic [3:0][31:0] dmap, next_dmap;
	logic [31:0] next_rdata;
	logic [3:0] a_blk, a_reg;
	logic [2:0] a_port;
	logic port_hit;
	logic [NB-1:0] ing_over_v, eg_over_v;
	logic [TW-1:0] tick_cnt, next_tick_cnt;
	logic tick;

	assign a_blk = reg_addr_i[7:4];
	assign a_reg = reg_addr_i[3:0];
	assign a_port = reg_addr_i[6:4];
	assign port_hit = a_blk < 4'(NPORT);

	// register writes: port settings held apart per port and direction, queue enable and maps global
	always_comb begin
		next_pctrl = pctrl;
		next_rlctrl = rlctrl;
		next_ing_code = ing_code;
		next_eg_code = eg_code;
		next_ratio = ratio;
		next_qrl_en = qrl_en;
		next_pmap = pmap;
		next_dmap = dmap;
		if (reg_wr_i && port_hit) begin
			if (a_reg == R_PCTRL)
				next_pctrl[a_port] = reg_wdata_i[6:0];
			if (a_reg == R_RLCTRL)
				next_rlctrl[a_port] = reg_wdata_i[4:0];
			for (int q = 0; q < NQ; q++) begin
				if (a_reg == R_ING0 + 4'(q))
					next_ing_code[a_port][q] = reg_wdata_i[6:0]; // see RULE3
				if (a_reg == R_EGR0 + 4'(q))
					next_eg_code[a_port][q] = reg_wdata_i[6:0]; // see RULE3
				if (a_reg == R_RAT0 + 4'(q))
					next_ratio[a_port][q] = reg_wdata_i[7:0]; // see RULE17
			end
		end
		if (reg_wr_i && a_blk == GBLK) begin
			if (a_reg == G_CTRL)
				next_qrl_en = reg_wdata_i[GC_QRL];
			if (a_reg == G_PMAP)
				next_pmap = reg_wdata_i[15:0]; // see RULE9
			for (int k = 0; k < 4; k++) begin
				if (a_reg == G_DMAP0 + 4'(k))
					next_dmap[k] = reg_wdata_i; // see RULE9
			end
		end
	end

	// read mux, data valid only in the cycle after the strobe
	always_comb begin
		next_rdata = 32'h00000000;
		if (reg_rd_i && port_hit) begin
			if (a_reg == R_PCTRL)
				next_rdata[6:0] = pctrl[a_port];
			if (a_reg == R_RLCTRL)
				next_rdata[4:0] = rlctrl[a_port];
			for (int q = 0; q < NQ; q++) begin
				if (a_reg == R_ING0 + 4'(q))
					next_rdata[6:0] = ing_code[a_port][q];
				if (a_reg == R_EGR0 + 4'(q))
					next_rdata[6:0] = eg_code[a_port][q];
				if (a_reg == R_RAT0 + 4'(q))
					next_rdata[7:0] = ratio[a_port][q];
			end
			if (a_reg == R_STAT)
				next_rdata[8:0] = {ing_fc_o[a_port],
					eg_over_v[a_port*NQ +: NQ], ing_over_v[a_port*NQ +: NQ]};
		end
		if (reg_rd_i && a_blk == GBLK) begin
			if (a_reg == G_CTRL)
				next_rdata[GC_QRL] = qrl_en;
			if (a_reg == G_PMAP)
				next_rdata[15:0] = pmap;
			for (int k = 0; k < 4; k++) begin
				if (a_reg == G_DMAP0 + 4'(k))
					next_rdata = dmap[k];
			end
		end
	end

	// configuration and read data registers
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			for (int p = 0; p < NPORT; p++) begin
				pctrl[p] <= PCTRL_RST;
				rlctrl[p] <= RLCTRL_RST;
				for (int q = 0; q < NQ; q++) begin
					ing_code[p][q] <= CODE_RST;
					eg_code[p][q] <= CODE_RST;
					ratio[p][q] <= RATIO_RST[q];
				end
			end
			qrl_en <= QRL_RST;
			pmap <= PMAP_RST;
			dmap <= DMAP_RST;
			reg_rdata_o <= 32'h00000000;
		end else if (ce_i) begin
			pctrl <= next_pctrl;
			rlctrl <= next_rlctrl;
			ing_code <= next_ing_code;
			eg_code <= next_eg_code;
			ratio <= next_ratio;
			qrl_en <= next_qrl_en;
			pmap <= next_pmap;
			dmap <= next_dmap;
			reg_rdata_o <= next_rdata;
		end
	end

	// refill tick
	assign tick = tick_cnt == TW'(TICK_CYCLES - 1);
	always_comb begin
		next_tick_cnt = tick ? '0 : tick_cnt + 1'b1;
	end
	always_ff @(posedge sys_clk_i) begin
		if (srst_i)
			tick_cnt <= '0;
		else if (ce_i)
			tick_cnt <= next_tick_cnt;
	end

	// bits a frame costs: DA..FCS plus optional gap and preamble
	function automatic logic [BW-1:0] frame_bits(input logic [10:0] len,
		input logic ifg, input logic pre);
		logic [12:0] b;
		b = 13'(len) + (ifg ? IFG_BYTES : 13'h0000) +
			(pre ? PRE_BYTES : 13'h0000); // see RULE5
		return BW'({b, 3'b000});
	endfunction

	// one bucket step: refill on tick, debit per frame, clamp at cap
	function automatic logic signed [BW-1:0] bkt_step(
		input logic signed [BW-1:0] b, input logic open, input logic add,
		input logic [BW-1:0] fill, input logic take, input logic [BW-1:0] cost);
		logic signed [BW+1:0] s;
		s = {{2{b[BW-1]}}, b};
		if (add)
			s = s + $signed({2'b00, fill});
		if (take)
			s = s - $signed({2'b00, cost});
		if (open || s > $signed({2'b00, BKT_CAP}))
			s = {2'b00, BKT_CAP};
		return s[BW-1:0];
	endfunction

	// ingress frame: priority, queue, class match, decision
	logic [1:0] f_prio, f_q;
	logic f_sel, f_lim, f_fc, f_drop, f_take;
	logic [BW-1:0] f_bits;
	logic [4:0] f_idx;
	always_comb begin
		if (ing_tagged_i)
			f_prio = pmap[{ing_pcp_i, 1'b0} +: 2]; // see RULE9
		else if (ing_ip_i)
			f_prio = dmap[ing_dscp_i[5:4]][{ing_dscp_i[3:0], 1'b0} +: 2];
		else
			f_prio = pctrl[ing_port_i][PC_PRIO +: 2]; // see RULE8
		case (prl_split_t'(pctrl[ing_port_i][PC_SPLIT +: 2]))
			SPL_FOUR: f_q = f_prio; // see RULE12
			SPL_TWO: f_q = {1'b0, f_prio[1]}; // see RULE12
			default: f_q = 2'h0;
		endcase
		if (!qrl_en)
			f_q = 2'h0; // see RULE10
		case (prl_sel_t'(rlctrl[ing_port_i][RL_SEL +: 2])) // see RULE6
			SEL_ALL: f_sel = 1'b1;
			SEL_MCAST: f_sel = ing_class_i == CL_MCAST ||
				ing_class_i == CL_BCAST;
			SEL_BCAST: f_sel = ing_class_i == CL_BCAST;
			SEL_FLOOD: f_sel = ing_class_i == CL_FLOOD;
			default: f_sel = 1'b1;
		endcase
		f_bits = frame_bits(ing_len_i, pctrl[ing_port_i][PC_IFG],
			pctrl[ing_port_i][PC_PRE]);
		f_idx = {ing_port_i, f_q};
		f_lim = f_sel && ing_over_v[f_idx];
		f_fc = rlctrl[ing_port_i][RL_FC];
		f_drop = (f_lim || ing_dst_full_i) && !f_fc; // see RULE7 see RULE15
		f_take = ing_valid_i && f_sel && !f_drop;
	end

	// ingress answer and per-port flow control
	logic next_ack, next_drop;
	logic [1:0] next_prio;
	logic [NPORT-1:0] fc_full, next_fc_full, next_fc;
	always_comb begin
		next_ack = ing_valid_i;
		next_drop = ing_valid_i && f_drop;
		next_prio = ing_valid_i ? f_prio : ing_prio_o;
		for (int p = 0; p < NPORT; p++) begin
			next_fc_full[p] = fc_full[p];
			if (ing_valid_i && ing_port_i == 3'(p))
				next_fc_full[p] = ing_dst_full_i; // see RULE15
			next_fc[p] = rlctrl[p][RL_FC] &&
				(|ing_over_v[p*NQ +: NQ] || next_fc_full[p]); // see RULE7
		end
	end
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			ing_ack_o <= 1'b0;
			ing_drop_o <= 1'b0;
			ing_prio_o <= 2'h0;
			fc_full <= '0;
			ing_fc_o <= '0;
		end else if (ce_i) begin
			ing_ack_o <= next_ack;
			ing_drop_o <= next_drop;
			ing_prio_o <= next_prio;
			fc_full <= next_fc_full;
			ing_fc_o <= next_fc;
		end
	end

	// egress grant waits for credit, which stretches the frame gap
	logic [4:0] e_idx;
	logic [BW-1:0] e_bits;
	assign e_idx = {eg_port_i, eg_queue_i};
	assign e_bits = frame_bits(eg_len_i, pctrl[eg_port_i][PC_IFG],
		pctrl[eg_port_i][PC_PRE]);
	assign eg_ready_o = !eg_over_v[e_idx]; // see RULE14

	// one ingress and one egress bucket per port and queue
	for (genvar i = 0; i < NB; i++) begin : g_bkt
		localparam int P = i / NQ;
		localparam int Q = i % NQ;
		logic [6:0] icode, ecode;
		logic [1:0] top;
		logic iopen, eopen;
		logic [BW-1:0] ifill, efill;
		logic [31:0] prod;
		logic signed [BW-1:0] ib, eb, next_ib, next_eb;
		always_comb begin
			icode = (qrl_en && pctrl[P][PC_SPLIT +: 2] != SPL_ONE) ?
				ing_code[P][Q] : ing_code[P][0]; // see RULE10 see RULE12
			case (prl_split_t'(pctrl[P][PC_SPLIT +: 2]))
				SPL_FOUR: top = 2'h3;
				SPL_TWO: top = 2'h1;
				default: top = 2'h0;
			endcase
			ecode = qrl_en ? eg_code[P][Q] : eg_code[P][top]; // see RULE13
			iopen = rate_open(icode, pctrl[P][PC_TEN]);
			eopen = rate_open(ecode, pctrl[P][PC_TEN]);
			ifill = rate_bits(icode);
			efill = rate_bits(ecode);
			prod = 32'(efill) * 32'(ratio[P][Q]);
			if (!qrl_en && 2'(Q) < top)
				efill = BW'(prod >> 3); // see RULE16 see RULE17
			next_ib = bkt_step(ib, iopen, tick, ifill,
				f_take && f_idx == 5'(i), f_bits);
			next_eb = bkt_step(eb, eopen, tick, efill,
				eg_valid_i && eg_ready_o && e_idx == 5'(i), e_bits);
		end
		always_ff @(posedge sys_clk_i) begin
			if (srst_i) begin
				ib <= BKT_CAP;
				eb <= BKT_CAP;
			end else if (ce_i) begin
				ib <= next_ib;
				eb <= next_eb;
			end
		end
		assign ing_over_v[i] = !iopen && ib <= 0;
		assign eg_over_v[i] = !eopen && eb <= 0; // see RULE15
	end

	// checks on buckets of ports 0 to 3 and frame answers
	logic [6:0] code00;
	logic [BW-1:0] kfill, mfill;
	logic quiet00;
	assign code00 = ing_code[0][0];
	assign kfill = BW'(code00 - CODE_MBPS_MAX) * BW'(KSTEP_BITS);
	assign mfill = BW'(code00) * BW'(MBPS_BITS);
	assign quiet00 = ce_i && !(ing_valid_i && ing_port_i == 3'h0) &&
		g_bkt[0].ib < 24'sh0F0000 && !g_bkt[0].iopen;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);

	sequence s_frame_in;
		ce_i && ing_valid_i;
	endsequence

	a_kbps_step: assert property (quiet00 && tick && code00 > CODE_MBPS_MAX
		|=> g_bkt[0].ib == $past(g_bkt[0].ib) + $past(kfill)) // see RULE1
		else $error("kbps refill step wrong");
	a_mbps_step: assert property (quiet00 && tick && code00 != 7'h00 &&
		code00 <= CODE_MBPS_MAX // see RULE2
		|=> g_bkt[0].ib == $past(g_bkt[0].ib) + $past(mfill))
		else $error("mbps refill step wrong");
	a_dir_apart: assert property (quiet00 && !tick // see RULE3
		|=> g_bkt[0].ib == $past(g_bkt[0].ib))
		else $error("ingress bucket moved by egress");
	a_ten_open: assert property (ce_i && pctrl[2][PC_TEN] && // see RULE4
		ing_code[2][0] > CODE_TEN_MAX && ing_code[2][0] <= CODE_MBPS_MAX &&
		!reg_wr_i |=> g_bkt[8].ib == BKT_CAP)
		else $error("10 Mbps port still limited");
	a_size_cost: assert property (ce_i && !tick && f_take && // see RULE5
		f_idx == 5'h0C && !g_bkt[12].iopen && pctrl[3][PC_IFG] &&
		!pctrl[3][PC_PRE] |=> g_bkt[12].ib == $past(g_bkt[12].ib) -
		BW'({13'($past(ing_len_i)) + IFG_BYTES, 3'b000}))
		else $error("frame cost wrong");
	a_class_skip: assert property (s_frame_in and !f_sel && // see RULE6
		ing_port_i == 3'h1 && !tick |=> g_bkt[4].ib == $past(g_bkt[4].ib))
		else $error("unselected class metered");
	a_over_drop: assert property (s_frame_in and f_lim && !f_fc // see RULE7
		|=> ing_ack_o && ing_drop_o)
		else $error("over-rate frame kept");
	a_fc_nodrop: assert property (s_frame_in and f_fc // see RULE7
		|=> ing_ack_o && !ing_drop_o ##0 ing_fc_o[$past(ing_port_i)] ||
		!$past(f_lim || ing_dst_full_i))
		else $error("flow control frame dropped");
	a_port_prio: assert property (s_frame_in and !ing_tagged_i && !ing_ip_i
		&& ing_port_i == 3'h0 && !reg_wr_i // see RULE8
		|=> ing_prio_o == pctrl[0][PC_PRIO +: 2])
		else $error("port priority wrong");
	a_pmap_dflt: assert property (s_frame_in and ing_tagged_i && // see RULE9
		pmap == PMAP_RST && ing_pcp_i == 3'h7 |=> ing_prio_o == 2'h3)
		else $error("tag remap wrong");
	a_qrl_off: assert property (s_frame_in and !qrl_en // see RULE10
		|-> f_idx[1:0] == 2'h0)
		else $error("queue meter used while off");
	a_eg_gap: assert property (ce_i && !tick && !g_bkt[0].eopen && // see RULE14
		g_bkt[0].eb <= 0 && !reg_wr_i |=> g_bkt[0].eb <= 0 ##0 eg_over_v[0])
		else $error("egress credit without tick");
	a_dst_full: assert property (s_frame_in and ing_dst_full_i && !f_fc
		|=> ing_drop_o) // see RULE15
		else $error("full memory frame kept");
	a_ratio_low: assert property (ce_i && !qrl_en && // see RULE16 RULE17
		pctrl[0][PC_SPLIT +: 2] == SPL_FOUR && ratio[0][0] == 8'h01
		|-> g_bkt[0].efill == (g_bkt[3].efill >> 3) &&
		g_bkt[3].efill == rate_bits(eg_code[0][3]))
		else $error("queue ratio wrong");
endmodule // prl_port_rate_limiter

// file: dv/prl_fabric_model.sv
module prl_fabric_model (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire logic offer_i,
	input wire logic [2:0] port_i,
	input wire logic [1:0] queue_i,
	input wire logic eg_ready_i,
	output logic eg_valid_o,
	output logic [2:0] eg_port_o,
	output logic [1:0] eg_queue_o,
	output logic [10:0] eg_len_o,
	output logic [7:0] taken_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [10:0] pat = 11'h000;

	// full-size candidates back to back; released lines change every cycle
	always @(posedge sys_clk_i) begin
		pat <= pat + 11'h001;
		if (srst_i || !offer_i) begin
			eg_valid_o <= 1'b0;
			eg_port_o <= pat[2:0];
			eg_queue_o <= pat[1:0];
			eg_len_o <= pat;
			taken_o <= 8'h00;
		end else begin
			// a candidate stays up until the block takes it
			if (eg_valid_o && eg_ready_i)
				taken_o <= taken_o + 8'h01;
			eg_valid_o <= 1'b1;
			eg_port_o <= port_i;
			eg_queue_o <= queue_i;
			eg_len_o <= 11'h7FF;
		end
	end
endmodule // prl_fabric_model

// file: dv/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import prl_pkg::*;
	logic sys_clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic [7:0] reg_addr_i = 8'h00;
	logic [31:0] reg_wdata_i = 32'h0000_0000;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [31:0] reg_rdata_o;
	logic ing_valid_i = 1'b0;
	logic [2:0] ing_port_i = 3'h0;
	logic [10:0] ing_len_i = 11'h000;
	prl_class_t ing_class_i = CL_UNI;
	logic ing_tagged_i = 1'b0;
	logic [2:0] ing_pcp_i = 3'h0;
	logic ing_ip_i = 1'b0;
	logic [5:0] ing_dscp_i = 6'h00;
	logic ing_dst_full_i = 1'b0;
	logic ing_ack_o;
	logic ing_drop_o;
	logic [1:0] ing_prio_o;
	logic [NPORT-1:0] ing_fc_o;
	logic eg_valid_i;
	logic [2:0] eg_port_i;
	logic [1:0] eg_queue_i;
	logic [10:0] eg_len_i;
	logic eg_ready_o;
	logic ce = 1'b1;
	logic offer = 1'b0;
	logic [2:0] o_port = 3'h0;
	logic [1:0] o_q = 2'h0;
	logic [7:0] taken;
	int n_mismatch = 0;
	int cmp_count = 0;

	prl_port_rate_limiter #(.TICK_CYCLES(50)) prl_port_rate_limiter_i (
		.sys_clk_i(sys_clk_i), .srst_i(srst_i), .ce_i(ce),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.ing_valid_i(ing_valid_i), .ing_port_i(ing_port_i),
		.ing_len_i(ing_len_i), .ing_class_i(ing_class_i),
		.ing_tagged_i(ing_tagged_i), .ing_pcp_i(ing_pcp_i),
		.ing_ip_i(ing_ip_i), .ing_dscp_i(ing_dscp_i),
		.ing_dst_full_i(ing_dst_full_i), .ing_ack_o(ing_ack_o),
		.ing_drop_o(ing_drop_o), .ing_prio_o(ing_prio_o),
		.ing_fc_o(ing_fc_o), .eg_valid_i(eg_valid_i),
		.eg_port_i(eg_port_i), .eg_queue_i(eg_queue_i),
		.eg_len_i(eg_len_i), .eg_ready_o(eg_ready_o));

	prl_fabric_model prl_fabric_model_i (
		.sys_clk_i(sys_clk_i), .srst_i(srst_i), .offer_i(offer),
		.port_i(o_port), .queue_i(o_q), .eg_ready_i(eg_ready_o),
		.eg_valid_o(eg_valid_i), .eg_port_o(eg_port_i),
		.eg_queue_o(eg_queue_i), .eg_len_o(eg_len_i), .taken_o(taken));

	// 100 MHz clock
	initial begin
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// one-cycle write strobe
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
	endtask

	// read data stand in the cycle after the strobe
	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b0;
		#1 d = reg_rdata_o;
	endtask

	// one full-size descriptor, answer taken one cycle later
	task automatic ing_send(input logic [2:0] p, input prl_class_t c,
		input logic tg, input logic [2:0] pcp, input logic ip,
		input logic [5:0] dscp, input logic full,
		output logic drop, output logic [1:0] prio);
		@(posedge sys_clk_i);
		ing_valid_i <= 1'b1;
		ing_port_i <= p;
		ing_len_i <= 11'h7FF;
		ing_class_i <= c;
		ing_tagged_i <= tg;
		ing_pcp_i <= pcp;
		ing_ip_i <= ip;
		ing_dscp_i <= dscp;
		ing_dst_full_i <= full;
		@(posedge sys_clk_i);
		ing_valid_i <= 1'b0;
		#1 chk("ing_ack_o", ing_ack_o, 32'h1);
		drop = ing_drop_o;
		prio = ing_prio_o;
	endtask

	// count frames of a burst that are not dropped
	task automatic ing_burst(input logic [2:0] p, input prl_class_t c,
		output int pass);
		logic d;
		logic [1:0] pr;
		pass = 0;
		for (int i = 0; i < 70; i++) begin
			ing_send(p, c, 1'b0, 3'h0, 1'b0, 6'h00, 1'b0, d, pr);
			pass += int'(d === 1'b0);
		end
	endtask

	// offer one queue for 150 cycles, report frames taken and final ready
	task automatic eg_run(input logic [2:0] p, input logic [1:0] q,
		output int n, output logic rdy);
		@(posedge sys_clk_i);
		o_port <= p;
		o_q <= q;
		offer <= 1'b1;
		repeat (150) @(posedge sys_clk_i);
		#1 n = int'(taken);
		rdy = eg_ready_o;
		@(posedge sys_clk_i);
		offer <= 1'b0;
		@(posedge sys_clk_i);
	endtask

	task automatic t_regs();
		logic [31:0] d;
		reg_rd({4'h0, R_PCTRL}, d);
		chk("pctrl", d, 32'h0);
		@(posedge sys_clk_i);
		#1 chk("rdata after", reg_rdata_o, 32'h0);
		for (int q = 0; q < NQ; q++) begin
			reg_rd({4'h2, R_RAT0 + 4'(q)}, d);
			chk("ratio", d, 32'h1 << q);
			reg_rd({GBLK, G_DMAP0 + 4'(q)}, d);
			chk("dscp map", d, {16{2'(q)}});
		end
		reg_rd({GBLK, G_PMAP}, d);
		chk("tag map", d, 32'h0000_FA50);
		reg_wr(8'h5F, 32'hFFFF_FFFF);
		reg_rd(8'h5F, d);
		chk("unmapped", d, 32'h0);
		// a write while the clock enable is low leaves the register alone
		@(posedge sys_clk_i);
		ce <= 1'b0;
		reg_wr({4'h0, R_EGR0 + 4'h1}, 32'h0000_0005);
		ce <= 1'b1;
		reg_rd({4'h0, R_EGR0 + 4'h1}, d);
		chk("frozen write", d, 32'h0);
		reg_wr({4'h0, R_ING0}, 32'h0000_0001);
		reg_rd({4'h0, R_ING0}, d);
		chk("ing code", d, 32'h1);
		$display("test regs done");
	endtask

	// 1 Mbps code: 2047-byte frames, bucket of 0x100000 bits
	task automatic t_ingress();
		int n;
		logic [31:0] d;
		ing_burst(3'h0, CL_UNI, n);
		chk("p0 passed", 32'(n), 32'd65);
		// 64 kbps code refills the emptied port 0 bucket only slowly
		reg_wr({4'h0, R_ING0}, 32'h0000_0065);
		repeat (120) @(posedge sys_clk_i);
		reg_rd({4'h0, R_STAT}, d);
		chk("p0 kbps over", {31'h0, d[0]}, 32'h1);
		reg_wr({4'h1, R_RLCTRL}, 32'h0000_0008);
		reg_wr({4'h1, R_ING0}, 32'h0000_0001);
		ing_burst(3'h1, CL_UNI, n);
		chk("p1 unicast", 32'(n), 32'd70);
		ing_burst(3'h1, CL_BCAST, n);
		chk("p1 bcast", 32'(n), 32'd65);
		reg_wr({4'h3, R_PCTRL}, 32'h0000_0020);
		reg_wr({4'h3, R_ING0}, 32'h0000_0001);
		ing_burst(3'h3, CL_UNI, n);
		chk("p3 with gap", 32'(n), 32'd64);
		reg_wr({4'h4, R_RLCTRL}, 32'h0000_0010);
		reg_wr({4'h4, R_ING0}, 32'h0000_0001);
		ing_burst(3'h4, CL_UNI, n);
		chk("p4 flow ctl", 32'(n), 32'd70);
		chk("ing_fc_o 4", 32'(ing_fc_o[4]), 32'h1);
		$display("test ingress done");
	endtask

	// 10BT port with a 20 Mbps code is open
	task automatic t_prio();
		logic d;
		logic [1:0] pr;
		int n;
		reg_wr({4'h2, R_PCTRL}, 32'h0000_000C);
		reg_wr({4'h2, R_ING0}, 32'h0000_0014);
		ing_send(3'h2, CL_UNI, 1'b0, 3'h0, 1'b0, 6'h00, 1'b0, d, pr);
		chk("port prio", 32'(pr), 32'h1);
		ing_send(3'h2, CL_UNI, 1'b1, 3'h5, 1'b0, 6'h00, 1'b0, d, pr);
		chk("tag prio", 32'(pr), 32'h2);
		ing_send(3'h2, CL_UNI, 1'b1, 3'h7, 1'b0, 6'h00, 1'b0, d, pr);
		chk("tag prio 7", 32'(pr), 32'h3);
		ing_send(3'h2, CL_UNI, 1'b0, 3'h0, 1'b1, 6'h3F, 1'b0, d, pr);
		chk("dscp prio", 32'(pr), 32'h3);
		reg_wr({GBLK, G_PMAP}, 32'h0000_0000);
		ing_send(3'h2, CL_UNI, 1'b1, 3'h5, 1'b0, 6'h00, 1'b0, d, pr);
		chk("remapped", 32'(pr), 32'h0);
		ing_send(3'h2, CL_UNI, 1'b0, 3'h0, 1'b0, 6'h00, 1'b1, d, pr);
		chk("dst full drop", 32'(d), 32'h1);
		ing_burst(3'h2, CL_UNI, n);
		chk("10BT open", 32'(n), 32'd70);
		$display("test prio done");
	endtask

	task automatic t_egress();
		int n;
		logic r;
		reg_wr({4'h0, R_PCTRL}, 32'h0000_0002);
		reg_wr({4'h0, R_EGR0 + 4'h3}, 32'h0000_0001);
		eg_run(3'h0, 2'h3, n, r);
		chk("top queue", 32'(n), 32'd65);
		chk("top stalled", 32'(r), 32'h0);
		eg_run(3'h0, 2'h0, n, r);
		chk("low queue", 32'(n), 32'd65);
		reg_wr({4'h1, R_PCTRL}, 32'h0000_0002);
		reg_wr({4'h1, R_EGR0 + 4'h3}, 32'h0000_0001);
		reg_wr({GBLK, G_CTRL}, 32'h0000_0008);
		eg_run(3'h1, 2'h0, n, r);
		chk("own code", 32'(n > 100), 32'h1);
		eg_run(3'h1, 2'h3, n, r);
		chk("top own", 32'(n), 32'd65);
		$display("test egress done");
	endtask

	// watchdog
	initial begin
		repeat (20000) @(posedge sys_clk_i);
		n_mismatch++;
		$display("MISMATCH watchdog expected end seen hang");
		end_of_test();
	end

	initial begin
		repeat (16) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		t_regs();
		t_ingress();
		t_prio();
		t_egress();
		end_of_test();
	end
endmodule // tb
